//--- design/block_transfer_address_controller.sv
// Address and sequence controller for block transfers between a peripheral and memory.
// Summary of operation
// - Initial register holds first address, incremented once per word moved.
// - Final register holds last address; equality with initial marks completion.
// - Key-load enable steers next final load into key register, then clears.
// - Only addresses and control are generated; data never passes through.
// - Selected sense answers low when the device is not busy.
// - Initialize instruction clears control state back to idle.
// - Word-ready rising loads initial or final register per load strobes.
// - Activate drives connect-enable low toward all peripheral controllers.
// - Controller-connected low makes the device raise connect-enable again.
// - Transfer-request low drives trap-in or trap-out low per direction.
// - Processor acknowledge low drives transfer-acknowledge low.
// - Address phase raises the output gate with initial address and key.
// - Function-ready rising ends address phase and increments initial register.
// - Transfer-acknowledge stays low until processor acknowledge returns high.
// - Equality drives device-stop low; connected high returns to not busy.
// - Deactivate low forces device-stop; connected high returns to not busy.
// - After abnormal stop the initial register holds last address plus one.
// - Map error low during an operation stops like an abnormal stop.
// - System reset input produces the same initialize as the instruction.
// - Completion of a block raises an interrupt request toward the processor.
//
// The register addresses and register access over Avalon-MM were decided locally.
`include "btac_consts.svh"

module block_transfer_address_controller
	import btac_pkg::*;
#(
	parameter int ADDR_W = `BTAC_ADDR_W,
	parameter int KEY_W = `BTAC_KEY_W
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Avalon-MM slave
	input wire logic [`BTAC_AVS_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Processor I/O bus
	input wire logic [ADDR_W-1:0] busWordIn,
	input wire logic wordReadyStrobe,
	input wire logic functionReadyStrobe,
	input wire logic processorAcknowledgeN,
	input wire logic loadInitialStrobeN,
	input wire logic loadFinalStrobe,
	input wire logic senseSelect,
	input wire logic systemResetInput,
	input wire logic mapErrorStopInputN,
	output logic [ADDR_W-1:0] busAddressOut,
	output logic [KEY_W-1:0] keyBitOutputs,
	output logic addressOutputGate,
	output logic senseResponseLineN,
	output logic trapInRequestN,
	output logic trapOutRequestN,
	output logic incrementEnable,
	output logic registersEqual,
	output logic completionInterruptRequest,
	// Peripheral controller cable
	input wire logic controllerConnectedN,
	input wire logic transferDirection,
	input wire logic transferRequestN,
	input wire logic controllerDeactivateN,
	output logic connectEnableN,
	output logic transferAcknowledgeN,
	output logic deviceStopN
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// The bus strobes come from another board, so they pass two flops and
	// edges are taken between the second and third stage only.
	logic [`BTAC_SYNC_W-1:0] syncMeta;
	logic [`BTAC_SYNC_W-1:0] syncIn;
	logic [`BTAC_SYNC_W-1:0] syncPrev;
	wire [`BTAC_SYNC_W-1:0] rawIn = {controllerDeactivateN, transferRequestN,
		transferDirection, controllerConnectedN, mapErrorStopInputN,
		systemResetInput, loadFinalStrobe, loadInitialStrobeN,
		processorAcknowledgeN, functionReadyStrobe, wordReadyStrobe};

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			syncMeta <= `BTAC_SYNC_RESET;
			syncIn <= `BTAC_SYNC_RESET;
			syncPrev <= `BTAC_SYNC_RESET;
		end else begin
			syncMeta <= rawIn;
			syncIn <= syncMeta;
			syncPrev <= syncIn;
		end
	end

	wire [`BTAC_SYNC_W-1:0] riseIn = syncIn & ~syncPrev;
	wire wordReadyRise = riseIn[`BTAC_SY_WORD_READY];
	wire funcReadyRise = riseIn[`BTAC_SY_FUNC_READY];
	wire sysResetRise = riseIn[`BTAC_SY_SYS_RESET];
	wire ackLow = !syncIn[`BTAC_SY_PROC_ACK_N];
	wire connectedLow = !syncIn[`BTAC_SY_CONNECTED_N];
	wire requestLow = !syncIn[`BTAC_SY_REQUEST_N];
	wire intoMemory = syncIn[`BTAC_SY_DIRECTION];

	// ------------------------------------------------------------
	// Avalon-MM slave decode
	// ------------------------------------------------------------
	// Every access is answered at the second edge: waitrequest is high in
	// the first cycle, which keeps the read path fully registered.
	logic avsDone;
	wire avsAccess = avs_read | avs_write;
	wire avsTake = avsAccess & avsDone;
	wire ctlHit = avs_address == {1'b0, `BTAC_OFS_CONTROL};
	wire ctlWrite = avsTake & avs_write & ctlHit;
	wire cmdActivate = ctlWrite & avs_writedata[`BTAC_CTL_ACTIVATE];
	wire cmdKeyEnable = ctlWrite & avs_writedata[`BTAC_CTL_KEY_ENABLE];
	wire cmdInitialize = (ctlWrite & avs_writedata[`BTAC_CTL_INITIALIZE]) | sysResetRise;

	assign avs_waitrequest = avsAccess & ~avsDone;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	seq_state_t state;
	seq_state_t next_state;
	logic [ADDR_W-1:0] initialAddr;
	logic [ADDR_W-1:0] finalAddr;
	logic [KEY_W-1:0] keyBits;
	logic keyEnable;
	logic lastWord;
	logic stopPending;
	logic abnormalStop;
	logic mapError;
	logic complete;

	wire active = state != ST_IDLE;
	wire deactivateReq = active & !syncIn[`BTAC_SY_DEACT_N];
	wire mapErrReq = active & !syncIn[`BTAC_SY_MAP_ERR_N];
	wire loadInitial = wordReadyRise & !syncIn[`BTAC_SY_LOAD_INIT_N];
	wire loadFinal = wordReadyRise & syncIn[`BTAC_SY_LOAD_FINAL];
	wire wordEnd = state == ST_DATA && !ackLow;
	wire stopDone = state == ST_STOPPING && !connectedLow;

	function automatic logic [31:0] widen(input logic [ADDR_W-1:0] v);
		widen = 32'(v);
	endfunction : widen

	// Unmapped offsets read as zero. The address registers are read-only here
	// because they are loaded from the processor bus pins alone.
	wire [31:0] statusWord = {26'h0, registersEqual, complete, keyEnable, mapError,
		abnormalStop, active};
	wire [31:0] readMux =
		(avs_address == {1'b0, `BTAC_OFS_INITIAL}) ? widen(initialAddr) :
		(avs_address == {1'b0, `BTAC_OFS_FINAL}) ? widen(finalAddr) :
		(avs_address == {1'b0, `BTAC_OFS_KEY}) ? 32'(keyBits) :
		(avs_address == `BTAC_OFS_STATUS) ? statusWord : 32'h0;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			avsDone <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			avsDone <= avsAccess & ~avsDone;
			if (avsAccess & ~avsDone & avs_read) begin
				avs_readdata <= readMux;
			end
		end
	end

	// ------------------------------------------------------------
	// Address and key registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			initialAddr <= '0;
			finalAddr <= '0;
			keyBits <= '0;
			keyEnable <= 1'b0;
		end else begin
			if (state == ST_ADDRESS && funcReadyRise) begin
				initialAddr <= initialAddr + 1'b1;
			end else if (loadInitial) begin
				initialAddr <= busWordIn;
			end
			if (loadFinal && keyEnable) begin
				keyBits <= busWordIn[KEY_W-1:0];
			end else if (loadFinal) begin
				finalAddr <= busWordIn;
			end
			// An enable instruction in the same cycle as a final load wins, so
			// the steer request is never lost.
			if (cmdKeyEnable) begin
				keyEnable <= 1'b1;
			end else if (loadFinal || cmdInitialize) begin
				keyEnable <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Sequence control
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (cmdActivate) begin
					next_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (connectedLow) begin
					next_state = ST_CONNECTED;
				end
			end
			ST_CONNECTED: begin
				if (stopPending || deactivateReq || mapErrReq) begin
					next_state = ST_STOPPING;
				end else if (requestLow) begin
					next_state = ST_TRAP;
				end
			end
			ST_TRAP: begin
				if (ackLow) begin
					next_state = ST_ADDRESS;
				end
			end
			ST_ADDRESS: begin
				if (funcReadyRise) begin
					next_state = ST_DATA;
				end
			end
			ST_DATA: begin
				if (!ackLow) begin
					next_state = (lastWord || stopPending) ? ST_STOPPING : ST_CONNECTED;
				end
			end
			ST_STOPPING: begin
				if (!connectedLow) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	// Initialize overrides every transition, a stop in progress included.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else if (cmdInitialize) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// A stop that arrives mid-word is held until the word ends, so the
	// processor and memory cycle is never cut short.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			lastWord <= 1'b0;
			stopPending <= 1'b0;
			abnormalStop <= 1'b0;
			mapError <= 1'b0;
			complete <= 1'b0;
			incrementEnable <= 1'b0;
		end else begin
			incrementEnable <= state == ST_ADDRESS && funcReadyRise;
			// The equal flag stays up after a finished block so software can
			// still read it; the next activate drops it before any word compares.
			if (state == ST_ADDRESS && funcReadyRise) begin
				lastWord <= initialAddr == finalAddr;
			end else if (cmdInitialize || cmdActivate) begin
				lastWord <= 1'b0;
			end
			// A stop input still held low while the device winds down keeps the
			// pending flag set past idle, so a new activate clears it as well.
			if (deactivateReq || mapErrReq) begin
				stopPending <= 1'b1;
			end else if (cmdInitialize || cmdActivate || stopDone) begin
				stopPending <= 1'b0;
			end
			if (deactivateReq) begin
				abnormalStop <= 1'b1;
			end else if (cmdInitialize || cmdActivate) begin
				abnormalStop <= 1'b0;
			end
			if (mapErrReq) begin
				mapError <= 1'b1;
			end else if (cmdInitialize || cmdActivate) begin
				mapError <= 1'b0;
			end
			if (stopDone && lastWord && !stopPending) begin
				complete <= 1'b1;
			end else if (cmdInitialize || cmdActivate) begin
				complete <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Output decode
	// ------------------------------------------------------------
	// Only the address and key leave on the bus; the data word itself runs
	// straight between peripheral and memory and is never sampled here.
	assign busAddressOut = initialAddr;
	assign keyBitOutputs = keyBits;
	assign addressOutputGate = state == ST_ADDRESS;
	// Connect-enable is low only while armed, so a second controller can never
	// be selected once the first one has answered.
	assign connectEnableN = state != ST_ARMED;
	assign trapInRequestN = !(state == ST_TRAP && intoMemory);
	assign trapOutRequestN = !(state == ST_TRAP && !intoMemory);
	assign transferAcknowledgeN = !(state == ST_ADDRESS || state == ST_DATA);
	assign deviceStopN = state != ST_STOPPING;
	assign senseResponseLineN = !(senseSelect && state == ST_IDLE);
	assign registersEqual = lastWord;
	assign completionInterruptRequest = complete;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Each property watches only what this module drives.

	increment_once_a: assert property (
		incrementEnable |-> initialAddr == $past(initialAddr) + 1'b1)
		else $error("initial register did not advance by one");

	final_equal_stop_a: assert property (
		(wordEnd && lastWord && !cmdInitialize) |=> !deviceStopN)
		else $error("device stop missing after last word");

	key_steer_a: assert property (
		(loadFinal && keyEnable && !cmdKeyEnable && !cmdInitialize)
		|=> keyBits == $past(busWordIn[KEY_W-1:0])
		&& finalAddr == $past(finalAddr) && !keyEnable)
		else $error("key load not steered away from final register");

	initialize_idle_a: assert property (
		cmdInitialize |=> state == ST_IDLE && connectEnableN && deviceStopN)
		else $error("initialize did not return to idle");

	connect_release_a: assert property (
		(state == ST_ARMED && connectedLow && !cmdInitialize) |=> connectEnableN)
		else $error("connect enable not released");

	trap_direction_a: assert property (
		(state == ST_CONNECTED && requestLow && !stopPending && !deactivateReq
		&& !mapErrReq && !cmdInitialize) |=> (trapInRequestN != trapOutRequestN)
		&& (trapInRequestN == !intoMemory))
		else $error("trap request wrong or missing");

	ack_hold_a: assert property (
		(state == ST_DATA && ackLow && !cmdInitialize) |=> !transferAcknowledgeN)
		else $error("transfer acknowledge dropped early");

	sense_idle_a: assert property (
		(senseSelect && !active) |-> !senseResponseLineN)
		else $error("sense answer wrong");

	abnormal_flag_a: assert property (
		(deactivateReq && !cmdInitialize) |=> abnormalStop)
		else $error("abnormal stop not recorded");

	avs_answer_a: assert property (
		(avsAccess && !avsDone) |=> !avs_waitrequest)
		else $error("bus access not answered in two cycles");

endmodule : block_transfer_address_controller

//--- design/btac_consts.svh
// Offsets, field positions, reset values and widths of the transfer address controller.
`ifndef BTAC_CONSTS_SVH
`define BTAC_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ------------------------------------------------------------
`define BTAC_OFS_CONTROL 4'h0
`define BTAC_OFS_INITIAL 4'h4
`define BTAC_OFS_FINAL 4'h8
`define BTAC_OFS_KEY 4'hc

// Status sits at byte 0x10, so the offset field is five bits wide.
`define BTAC_OFS_STATUS 5'h10
`define BTAC_AVS_ADDR_W 5

// ------------------------------------------------------------
// Control register bits (write one to issue the instruction)
// ------------------------------------------------------------
`define BTAC_CTL_ACTIVATE 0
`define BTAC_CTL_INITIALIZE 1
`define BTAC_CTL_KEY_ENABLE 2

// ------------------------------------------------------------
// Status register bits
// ------------------------------------------------------------
`define BTAC_ST_BUSY 0
`define BTAC_ST_ABNORMAL 1
`define BTAC_ST_MAP_ERROR 2
`define BTAC_ST_KEY_ENABLE 3
`define BTAC_ST_COMPLETE 4
`define BTAC_ST_EQUAL 5

// ------------------------------------------------------------
// Widths and reset values
// ------------------------------------------------------------
`define BTAC_ADDR_W 16
`define BTAC_KEY_W 4
`define BTAC_SYNC_W 11
`define BTAC_SYNC_RESET 11'h7ff

// Bit positions inside the synchroniser vector.
`define BTAC_SY_WORD_READY 0
`define BTAC_SY_FUNC_READY 1
`define BTAC_SY_PROC_ACK_N 2
`define BTAC_SY_LOAD_INIT_N 3
`define BTAC_SY_LOAD_FINAL 4
`define BTAC_SY_SYS_RESET 5
`define BTAC_SY_MAP_ERR_N 6
`define BTAC_SY_CONNECTED_N 7
`define BTAC_SY_DIRECTION 8
`define BTAC_SY_REQUEST_N 9
`define BTAC_SY_DEACT_N 10

`endif

//--- design/btac_pkg.sv
// Types shared by the transfer address controller.
package btac_pkg;

	// ------------------------------------------------------------
	// Sequence control states
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ARMED = 7'h02,
		ST_CONNECTED = 7'h04,
		ST_TRAP = 7'h08,
		ST_ADDRESS = 7'h10,
		ST_DATA = 7'h20,
		ST_STOPPING = 7'h40
	} seq_state_t;

endpackage : btac_pkg

//--- verif/periph_model.sv
// Behavioural peripheral controller that sits on the far end of the cable.
module periph_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Bench control
	input wire logic selectDevice,
	input wire logic wantDirection,
	input wire logic pause,
	input wire logic abortNow,
	// Cable from the device
	input wire logic connectEnableN,
	input wire logic transferAcknowledgeN,
	input wire logic deviceStopN,
	// Cable to the device
	output logic controllerConnectedN,
	output logic transferDirection,
	output logic transferRequestN,
	output logic controllerDeactivateN
);
	timeunit 1ns;
	timeprecision 1ps;

	always @(posedge ref_clk) controllerDeactivateN <= !abortNow;

	initial begin
		controllerConnectedN = 1'b1;
		transferDirection = 1'b0;
		transferRequestN = 1'b1;
		forever begin
			@(negedge ref_clk);
			if (nrst && selectDevice && connectEnableN === 1'b0) begin
				@(posedge ref_clk);
				controllerConnectedN <= 1'b0;
				transferDirection <= wantDirection;
				@(negedge ref_clk);
				while (deviceStopN !== 1'b0) begin
					if (transferAcknowledgeN === 1'b0) begin
						@(posedge ref_clk);
						transferRequestN <= 1'b1;
						while (transferAcknowledgeN !== 1'b1) @(negedge ref_clk);
						// Fifty nanoseconds high needs thirteen cycles at this clock.
						repeat (13) @(posedge ref_clk);
					end else if (!pause && transferRequestN) begin
						@(posedge ref_clk);
						transferRequestN <= 1'b0;
					end
					@(negedge ref_clk);
				end
				@(posedge ref_clk);
				transferRequestN <= 1'b1;
				controllerConnectedN <= 1'b1;
				// A released direction line must not keep a plausible level.
				transferDirection <= ~transferDirection;
			end
		end
	end
endmodule : periph_model

//--- verif/block_transfer_address_controller_tb.sv
// Self-checking bench for the transfer address controller.
`include "btac_consts.svh"

module block_transfer_address_controller_tb
	import btac_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, wordReadyStrobe;
	logic functionReadyStrobe, processorAcknowledgeN, loadInitialStrobeN, loadFinalStrobe;
	logic senseSelect, systemResetInput, mapErrorStopInputN, addressOutputGate;
	logic senseResponseLineN, trapInRequestN, trapOutRequestN, incrementEnable;
	logic registersEqual, completionInterruptRequest, controllerConnectedN, transferDirection;
	logic transferRequestN, controllerDeactivateN, connectEnableN, transferAcknowledgeN;
	logic deviceStopN, selectDevice, expDir, pause, abortNow;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] busWordIn, busAddressOut, expAddr;
	logic [3:0] keyBitOutputs, expKey;
	int failures, num_checks, words, m;

	block_transfer_address_controller dut_u (.ref_clk, .nrst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .busWordIn,
		.wordReadyStrobe, .functionReadyStrobe, .processorAcknowledgeN, .loadInitialStrobeN,
		.loadFinalStrobe, .senseSelect, .systemResetInput, .mapErrorStopInputN, .busAddressOut,
		.keyBitOutputs, .addressOutputGate, .senseResponseLineN, .trapInRequestN,
		.trapOutRequestN, .incrementEnable, .registersEqual, .completionInterruptRequest,
		.controllerConnectedN, .transferDirection, .transferRequestN, .controllerDeactivateN,
		.connectEnableN, .transferAcknowledgeN, .deviceStopN);

	periph_model periph_u (.ref_clk, .nrst, .selectDevice, .wantDirection(expDir), .pause,
		.abortNow, .connectEnableN, .transferAcknowledgeN, .deviceStopN, .controllerConnectedN,
		.transferDirection, .transferRequestN, .controllerDeactivateN);

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic waitFor(ref logic sig, input logic val);
		for (int i = 0; i < 400 && sig !== val; i++) @(negedge ref_clk);
	endtask : waitFor

	task avWrite(input logic [4:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : avWrite

	task avRead(input logic [4:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask : avRead

	// Every pin level is held four cycles so the synchronisers always see it.
	task loadPin(input logic initN, input logic fin, input logic [15:0] w);
		@(posedge ref_clk);
		busWordIn <= w;
		loadInitialStrobeN <= initN;
		loadFinalStrobe <= fin;
		repeat (4) @(posedge ref_clk);
		wordReadyStrobe <= 1'b1;
		repeat (4) @(posedge ref_clk);
		wordReadyStrobe <= 1'b0;
		repeat (4) @(posedge ref_clk);
		loadInitialStrobeN <= 1'b1;
		loadFinalStrobe <= 1'b0;
	endtask : loadPin

	task runBlock(input logic dir, input int fault);
		expDir = dir;
		words = 0;
		avWrite(`BTAC_OFS_CONTROL, 32'h1);
		waitFor(connectEnableN, 1'b0);
		check(32'(connectEnableN), 32'h0);
		@(posedge ref_clk);
		selectDevice <= 1'b1;
		waitFor(connectEnableN, 1'b1);
		check(32'(connectEnableN), 32'h1);
		@(posedge ref_clk);
		selectDevice <= 1'b0;
		senseSelect <= 1'b1;
		@(negedge ref_clk);
		check(32'(senseResponseLineN), 32'h1);
		if (fault != 0) begin
			for (m = 0; m < 400 && words < 1; m++) @(negedge ref_clk);
			@(posedge ref_clk);
			pause <= 1'b1;
			abortNow <= (fault == 1);
			mapErrorStopInputN <= (fault != 2);
		end
		waitFor(deviceStopN, 1'b0);
		check(32'(deviceStopN), 32'h0);
		waitFor(senseResponseLineN, 1'b0);
		check(32'(senseResponseLineN), 32'h0);
		@(posedge ref_clk);
		pause <= 1'b0;
		abortNow <= 1'b0;
		mapErrorStopInputN <= 1'b1;
		senseSelect <= 1'b0;
	endtask : runBlock

	task results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results

	// ------------------------------------------------------------
	// Processor side answering every trap
	// ------------------------------------------------------------
	always begin
		@(negedge ref_clk);
		if (trapInRequestN === 1'b0 || trapOutRequestN === 1'b0) begin
			check(32'(trapInRequestN), 32'(!expDir));
			check(32'(trapOutRequestN), 32'(expDir));
			@(posedge ref_clk);
			processorAcknowledgeN <= 1'b0;
			waitFor(addressOutputGate, 1'b1);
			check(32'(transferAcknowledgeN), 32'h0);
			check(32'(busAddressOut), 32'(expAddr));
			check(32'(keyBitOutputs), 32'(expKey));
			@(posedge ref_clk);
			functionReadyStrobe <= 1'b1;
			waitFor(incrementEnable, 1'b1);
			check(32'(incrementEnable), 32'h1);
			@(posedge ref_clk);
			wordReadyStrobe <= 1'b1;
			repeat (4) @(negedge ref_clk);
			check(32'(transferAcknowledgeN), 32'h0);
			@(posedge ref_clk);
			processorAcknowledgeN <= 1'b1;
			functionReadyStrobe <= 1'b0;
			wordReadyStrobe <= 1'b0;
			waitFor(transferAcknowledgeN, 1'b1);
			check(32'(transferAcknowledgeN), 32'h1);
			words++;
			expAddr++;
		end
	end

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		failures++;
		results();
	end

	initial begin
		{nrst, avs_read, avs_write, wordReadyStrobe, functionReadyStrobe} = '0;
		{loadFinalStrobe, senseSelect, systemResetInput, selectDevice, pause, abortNow} = '0;
		{processorAcknowledgeN, loadInitialStrobeN, mapErrorStopInputN, expDir} = '1;
		avs_address = '0;
		avs_writedata = '0;
		busWordIn = '0;
		expAddr = '0;
		expKey = '0;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd, 32'h0);
		avRead(5'h14, rd);
		check(rd, 32'h0);
		avWrite(`BTAC_OFS_INITIAL, 32'h1234);
		avRead(`BTAC_OFS_INITIAL, rd);
		check(rd, 32'h0);
		$display("test reset done");
		loadPin(1'b0, 1'b0, 16'h0003);
		loadPin(1'b1, 1'b1, 16'h0005);
		avRead(`BTAC_OFS_INITIAL, rd);
		check(rd, 32'h3);
		avRead(`BTAC_OFS_FINAL, rd);
		check(rd, 32'h5);
		avWrite(`BTAC_OFS_CONTROL, 32'h4);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h8, 32'h8);
		loadPin(1'b1, 1'b1, 16'h000a);
		check(32'(keyBitOutputs), 32'ha);
		avRead(`BTAC_OFS_FINAL, rd);
		check(rd, 32'h5);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h8, 32'h0);
		$display("test loads done");
		expAddr = 16'h0003;
		expKey = 4'ha;
		runBlock(1'b1, 0);
		check(32'(words), 32'h3);
		check(32'(registersEqual), 32'h1);
		check(32'(completionInterruptRequest), 32'h1);
		avRead(`BTAC_OFS_INITIAL, rd);
		check(rd, 32'h6);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h33, 32'h30);
		$display("test block done");
		loadPin(1'b0, 1'b0, 16'h0010);
		loadPin(1'b1, 1'b1, 16'h0020);
		expAddr = 16'h0010;
		runBlock(1'b0, 1);
		check(32'(words), 32'h1);
		check(32'(completionInterruptRequest), 32'h0);
		avRead(`BTAC_OFS_INITIAL, rd);
		check(rd, 32'h11);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h3, 32'h2);
		$display("test abnormal done");
		loadPin(1'b0, 1'b0, 16'h0030);
		loadPin(1'b1, 1'b1, 16'h0040);
		expAddr = 16'h0030;
		runBlock(1'b1, 2);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h5, 32'h4);
		$display("test map error done");
		avWrite(`BTAC_OFS_CONTROL, 32'h1);
		waitFor(connectEnableN, 1'b0);
		avWrite(`BTAC_OFS_CONTROL, 32'h2);
		waitFor(connectEnableN, 1'b1);
		check(32'(connectEnableN), 32'h1);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h1, 32'h0);
		avWrite(`BTAC_OFS_CONTROL, 32'h1);
		waitFor(connectEnableN, 1'b0);
		@(posedge ref_clk);
		systemResetInput <= 1'b1;
		repeat (4) @(posedge ref_clk);
		systemResetInput <= 1'b0;
		waitFor(connectEnableN, 1'b1);
		check(32'(connectEnableN), 32'h1);
		avRead(`BTAC_OFS_STATUS, rd);
		check(rd & 32'h1, 32'h0);
		$display("test initialize done");
		results();
	end
endmodule : block_transfer_address_controller_tb
